// ==== smf_defs.vh ====
/*
 * constants for the operating-mode state machine: mode codes, field
 * positions, reset values and timing figures.
 * assumes inclusion by bare name from the design files of this block.
 */
`ifndef SMF_DEFS_VH
`define SMF_DEFS_VH

// ----------------------------------------------------------------------
// operating modes (also the encoding of the mode field)
// ----------------------------------------------------------------------
`define SMF_MODE_W 3
`define SMF_MODE_INIT 3'h0
`define SMF_MODE_NORMAL 3'h1
`define SMF_MODE_STOP 3'h2
`define SMF_MODE_SLEEP 3'h3
`define SMF_MODE_RESTART 3'h4
`define SMF_MODE_FAILSAFE 3'h5

// ----------------------------------------------------------------------
// hardware control register and wake level status register layout
// ----------------------------------------------------------------------
`define SMF_HWCTRL_CFG_BIT 0
`define SMF_HWCTRL_FOON_BIT 1
`define SMF_WKLVL_LATCHED_PIN_CONFIG_BIT 0
`define SMF_CFG_SEL_RST 1'b1

// ----------------------------------------------------------------------
// timing figures (clock 200 MHz)
// ----------------------------------------------------------------------
`define SMF_CLK_MHZ 200
`define SMF_RESET_DELAY_US 10
`define SMF_LONG_WINDOW_US 200
`define SMF_CFG_FILTER_US 2
`define SMF_RESET_DELAY_CYC (`SMF_RESET_DELAY_US * `SMF_CLK_MHZ)
`define SMF_LONG_WINDOW_CYC (`SMF_LONG_WINDOW_US * `SMF_CLK_MHZ)
`define SMF_CFG_FILTER_CYC (`SMF_CFG_FILTER_US * `SMF_CLK_MHZ)

`endif

// ==== smf_cfg_filter.v ====
/*
 * continuous filter for the configuration level on the interrupt pin.
 * assumes i_level is already synchronised to i_ref_clk.
 */
`timescale 1ns/1ps
module smf_cfg_filter #(
    parameter FILT_CYC = 400,
    parameter CNT_W = 16
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_sys_rst,
    // control
    input wire i_enable,
    input wire i_level,
    // result
    output reg o_stable,
    output reg o_value
);

// ----------------------------------------------------------------------
// stability counter
// ----------------------------------------------------------------------
reg [CNT_W-1:0] cnt_q;
reg last_q;

// a level counts only after holding the full filter time; a change
// restarts the count, so no stable level means o_stable stays low
always @(posedge i_ref_clk) begin
    if (i_sys_rst || !i_enable) begin
        cnt_q <= {CNT_W{1'b0}};
        last_q <= 1'b0;
        o_stable <= 1'b0;
        o_value <= 1'b0;
    end else if (i_level != last_q) begin
        last_q <= i_level;
        cnt_q <= {CNT_W{1'b0}};
        o_stable <= 1'b0;
    end else if (cnt_q < FILT_CYC[CNT_W-1:0] - 1'b1) begin
        cnt_q <= cnt_q + 1'b1;
    end else begin
        o_stable <= 1'b1;
        o_value <= last_q;
    end
end

endmodule

// ==== smf_mode_fsm.v ====
/*
 * operating-mode state machine: init, normal, restart and fail-safe
 * transitions, hardware configuration latch, fail outputs, reset output.
 * assumes a decoded command port from an spi front end on i_ref_clk,
 * analog comparator flags as asynchronous pins, i_sys_rst as power-on.
 */
`timescale 1ns/1ps
`include "smf_defs.vh"
module smf_mode_fsm #(
    parameter RESET_DELAY_CYC = `SMF_RESET_DELAY_CYC,
    parameter LONG_WINDOW_CYC = `SMF_LONG_WINDOW_CYC,
    parameter CFG_FILTER_CYC = `SMF_CFG_FILTER_CYC
) (
    // clock and power-on reset
    input wire i_ref_clk,
    input wire i_sys_rst,
    // asynchronous analog and pin inputs
    input wire i_main_regulator_ok,
    input wire i_main_overvoltage,
    input wire i_int_pin,
    input wire i_fail3_debug_select_pin,
    input wire i_wake_event,
    // decoded host commands (same clock)
    input wire i_cmd_valid,
    input wire i_cmd_mode_wr,
    input wire [`SMF_MODE_W-1:0] i_operating_mode_field,
    input wire i_wd_trigger,
    input wire i_wd_failure,
    input wire i_cfg_sel_wr,
    input wire i_cfg_sel,
    input wire i_fail_output_test_bit,
    input wire i_overvoltage_reset_enable,
    input wire i_por_flag_clr,
    input wire i_ov_flag_clr,
    input wire i_cyc_wr,
    input wire [3:0] i_cyc_sense_hs_en,
    input wire i_cyc_sense_timer,
    input wire i_cyc_wake_en,
    input wire i_cyc_wake_timer,
    input wire i_supply_on_wr,
    input wire i_second_regulator_on,
    input wire i_third_regulator_on,
    input wire i_transceiver_on,
    input wire [3:0] i_high_side_switches_on,
    // mode and status
    output reg [`SMF_MODE_W-1:0] o_operating_mode_field,
    output reg o_cfg_sel,
    output reg o_latched_pin_config,
    output reg o_dev_mode,
    output reg o_por_flag,
    output reg o_main_overvoltage_flag,
    output reg o_main_undervoltage_flag,
    output reg [1:0] o_wd_fail_cnt,
    output reg o_wd_window_long,
    output reg o_wd_run,
    // pins
    output reg o_reset_output_n,
    output reg o_int_pd_oe,
    output reg o_int_n,
    output reg o_fail_outputs,
    // supplies and peripherals
    output reg o_second_regulator_en,
    output reg o_third_regulator_en,
    output reg o_transceiver_en,
    output reg [3:0] o_high_side_switches_en,
    output reg [3:0] o_cyc_sense_hs_en,
    output reg o_cyc_sense_timer,
    output reg o_cyc_wake_en,
    output reg o_cyc_wake_timer
);

// ----------------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------------
localparam NSYNC = 5;
reg [NSYNC-1:0] s1_q;
reg [NSYNC-1:0] s2_q;
wire [NSYNC-1:0] raw_in = {i_wake_event, i_fail3_debug_select_pin, i_int_pin,
                          i_main_overvoltage, i_main_regulator_ok};

// two stages for each async pin; only s2 is read by logic
always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
        s1_q <= {NSYNC{1'b0}};
        s2_q <= {NSYNC{1'b0}};
    end else begin
        s1_q <= raw_in;
        s2_q <= s1_q;
    end
end

wire reg_ok = s2_q[0];
wire ov_s = s2_q[1];
wire int_s = s2_q[2];
wire test_s = s2_q[3];
wire wake_s = s2_q[4];

// ----------------------------------------------------------------------
// state and timers
// ----------------------------------------------------------------------
localparam TW = 24;
reg [TW-1:0] tmr_q;
reg [TW-1:0] wd_q;
reg ov_prev_q;
reg first_ok_q;
reg rst_prev_q;
reg fail_restart_q;
reg from_init_q;
wire cfg_stable;
wire cfg_value;

// is the mode one of the known, host-selectable codes
function legal_mode;
    input [`SMF_MODE_W-1:0] m;
    begin
        legal_mode = (m == `SMF_MODE_NORMAL) || (m == `SMF_MODE_STOP) ||
                     (m == `SMF_MODE_SLEEP);
    end
endfunction

// pull-down and filter are active only while reset is driven low
smf_cfg_filter #(
    .FILT_CYC(CFG_FILTER_CYC),
    .CNT_W(TW)
) u_filt (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_enable(o_int_pd_oe),
    .i_level(int_s),
    .o_stable(cfg_stable),
    .o_value(cfg_value)
);

wire ov_rise = ov_s & ~ov_prev_q;
wire wd_expired = o_wd_run && !o_dev_mode && (wd_q == {TW{1'b0}});
wire wd_fail_ev = (i_wd_failure || wd_expired) && !o_dev_mode;
wire in_run = (o_operating_mode_field == `SMF_MODE_NORMAL) ||
              (o_operating_mode_field == `SMF_MODE_STOP) ||
              (o_operating_mode_field == `SMF_MODE_INIT);

// ----------------------------------------------------------------------
// main mode sequencer
// ----------------------------------------------------------------------
// the power-on reset clears the latch; each reset release re-latches it while the por flag is set
always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
        o_operating_mode_field <= `SMF_MODE_INIT;
        o_cfg_sel <= `SMF_CFG_SEL_RST;
        o_latched_pin_config <= 1'b0;
        o_dev_mode <= 1'b0;
        o_por_flag <= 1'b1;
        o_main_overvoltage_flag <= 1'b0;
        o_main_undervoltage_flag <= 1'b0;
        o_wd_fail_cnt <= 2'h0;
        o_wd_window_long <= 1'b1;
        o_wd_run <= 1'b0;
        o_reset_output_n <= 1'b0;
        o_int_pd_oe <= 1'b0;
        o_int_n <= 1'b1;
        o_fail_outputs <= 1'b0;
        tmr_q <= {TW{1'b0}};
        wd_q <= {TW{1'b0}};
        ov_prev_q <= 1'b0;
        first_ok_q <= 1'b0;
        rst_prev_q <= 1'b0;
        fail_restart_q <= 1'b0;
        from_init_q <= 1'b1;
    end else begin
        ov_prev_q <= ov_s;
        rst_prev_q <= o_reset_output_n;
        o_int_n <= 1'b1;
        // reset delay: low while regulator low, then count delay
        if (!reg_ok) begin
            o_reset_output_n <= 1'b0;
            tmr_q <= {TW{1'b0}};
            // power-up undervoltage is not flagged before first release
            if (first_ok_q && in_run)
                o_main_undervoltage_flag <= 1'b1;
        end else if (!o_reset_output_n) begin
            if (tmr_q < RESET_DELAY_CYC[TW-1:0] - 1'b1)
                tmr_q <= tmr_q + 1'b1;
            else
                o_reset_output_n <= 1'b1;
        end
        // pull-down while low, reactivated every reset while por flag set
        o_int_pd_oe <= reg_ok && !o_reset_output_n && (!first_ok_q || o_por_flag);
        // latch configuration at rising reset edge
        if (o_reset_output_n && !rst_prev_q && (!first_ok_q || o_por_flag)) begin
            o_latched_pin_config <= cfg_stable ? cfg_value : 1'b0;
            if (!first_ok_q)
                o_dev_mode <= ~test_s;
            first_ok_q <= 1'b1;
        end
        // watchdog starts with long window at each reset release
        if (o_reset_output_n && !rst_prev_q) begin
            o_wd_run <= 1'b1;
            o_wd_window_long <= 1'b1;
            wd_q <= LONG_WINDOW_CYC[TW-1:0];
            if (o_operating_mode_field == `SMF_MODE_RESTART) begin
                o_operating_mode_field <= `SMF_MODE_NORMAL;
                from_init_q <= 1'b0;
            end
        end else if (i_wd_trigger) begin
            o_wd_window_long <= 1'b0;
            wd_q <= LONG_WINDOW_CYC[TW-1:0];
        end else if (o_wd_run && !o_dev_mode && wd_q != {TW{1'b0}}) begin
            wd_q <= wd_q - 1'b1;
        end
        if (i_cfg_sel_wr)
            o_cfg_sel <= i_cfg_sel;
        if (i_por_flag_clr)
            o_por_flag <= 1'b0;
        // host commands; init leaves on any command, legal or not
        if (i_cmd_valid && o_reset_output_n) begin
            if (o_operating_mode_field == `SMF_MODE_INIT)
                o_operating_mode_field <= `SMF_MODE_NORMAL;
            else if (i_cmd_mode_wr && legal_mode(i_operating_mode_field) &&
                     o_operating_mode_field == `SMF_MODE_NORMAL)
                o_operating_mode_field <= i_operating_mode_field;
        end
        // fail output test in normal mode only
        if (i_cmd_valid && o_operating_mode_field == `SMF_MODE_NORMAL && !fail_restart_q)
            o_fail_outputs <= i_fail_output_test_bit;
        // wake: interrupt in normal/stop, dropped in init
        if (wake_s && (o_operating_mode_field == `SMF_MODE_NORMAL ||
                       o_operating_mode_field == `SMF_MODE_STOP))
            o_int_n <= 1'b0;
        // overvoltage event; the set wins over a simultaneous clear
        if (ov_rise && o_reset_output_n) begin
            o_main_overvoltage_flag <= 1'b1;
            if (i_overvoltage_reset_enable) begin
                o_fail_outputs <= 1'b1;
                fail_restart_q <= 1'b1;
                o_reset_output_n <= 1'b0;
                tmr_q <= {TW{1'b0}};
                o_operating_mode_field <= o_latched_pin_config ?
                    `SMF_MODE_RESTART : `SMF_MODE_FAILSAFE;
            end
        end else if (i_ov_flag_clr) begin
            o_main_overvoltage_flag <= 1'b0;
        end
        // watchdog failure reaction by configuration
        if (wd_fail_ev && o_reset_output_n && in_run) begin
            o_wd_fail_cnt <= (o_wd_fail_cnt == 2'h3) ? 2'h3 : o_wd_fail_cnt + 2'h1;
            o_reset_output_n <= 1'b0;
            o_wd_run <= 1'b0;
            tmr_q <= {TW{1'b0}};
            if (o_cfg_sel || o_wd_fail_cnt != 2'h0) begin
                o_fail_outputs <= 1'b1;
                fail_restart_q <= 1'b1;
            end
            if (o_latched_pin_config || (!o_cfg_sel && o_wd_fail_cnt == 2'h0))
                o_operating_mode_field <= `SMF_MODE_RESTART;
            else
                o_operating_mode_field <= `SMF_MODE_FAILSAFE;
        end
    end
end

// ----------------------------------------------------------------------
// supplies, switches, cyclic functions
// ----------------------------------------------------------------------
// second regulator and switches forced off in restart/fail-safe; third regulator and transceiver off in init
always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
        o_second_regulator_en <= 1'b0;
        o_third_regulator_en <= 1'b0;
        o_transceiver_en <= 1'b0;
        o_high_side_switches_en <= 4'h0;
        o_cyc_sense_hs_en <= 4'h0;
        o_cyc_sense_timer <= 1'b0;
        o_cyc_wake_en <= 1'b0;
        o_cyc_wake_timer <= 1'b0;
    end else if (o_operating_mode_field == `SMF_MODE_RESTART ||
                 o_operating_mode_field == `SMF_MODE_FAILSAFE) begin
        o_second_regulator_en <= 1'b0;
        o_high_side_switches_en <= 4'h0;
    end else if (o_operating_mode_field == `SMF_MODE_INIT) begin
        // init hands over to normal with these off; restart keeps them as set
        if (from_init_q) begin
            o_third_regulator_en <= 1'b0;
            o_transceiver_en <= 1'b0;
        end
    end else if (o_operating_mode_field == `SMF_MODE_NORMAL) begin
        if (i_supply_on_wr) begin
            o_second_regulator_en <= i_second_regulator_on;
            o_third_regulator_en <= i_third_regulator_on;
            o_transceiver_en <= i_transceiver_on;
            o_high_side_switches_en <= i_high_side_switches_on;
        end
        if (i_cyc_wr) begin
            o_cyc_sense_hs_en <= i_cyc_sense_hs_en;
            o_cyc_sense_timer <= i_cyc_sense_timer;
            o_cyc_wake_en <= i_cyc_wake_en;
            o_cyc_wake_timer <= i_cyc_wake_timer;
        end
    end
end

endmodule

// ==== smf_mode_fsm_chk.sv ====
/*
 * port checker for the operating-mode state machine.
 * assumes it is bound to smf_mode_fsm and sees only its ports.
 */
`timescale 1ns/1ps
`include "smf_defs.vh"
module smf_mode_fsm_chk #(
    parameter int RESET_DELAY_CYC = 20
) (
    // clock, reset and inputs watched
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_wd_failure,
    input wire i_cmd_valid,
    input wire i_overvoltage_reset_enable,
    // outputs watched
    input logic [`SMF_MODE_W-1:0] o_operating_mode_field,
    input logic o_latched_pin_config,
    input logic o_cfg_sel,
    input logic o_dev_mode,
    input logic o_por_flag,
    input logic o_main_overvoltage_flag,
    input logic o_main_undervoltage_flag,
    input logic o_reset_output_n,
    input logic o_int_pd_oe,
    input logic o_int_n,
    input logic o_fail_outputs
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // margin covers the pin synchronisers and the exit edge
    localparam int RD_MAX = RESET_DELAY_CYC + 8;
    wire [2:0] md = o_operating_mode_field;
    // failures are checked only while running normally with the watchdog live
    wire nrm = o_reset_output_n && !o_dev_mode && (md == `SMF_MODE_NORMAL);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_init_quiet; (md == `SMF_MODE_INIT) |-> o_int_n; endproperty
    a_init_quiet: assert property (p_init_quiet) else $error("wake signalled in init");
    property p_pu_quiet;
        !o_reset_output_n && (md == `SMF_MODE_INIT) |-> !o_main_undervoltage_flag && !o_fail_outputs;
    endproperty
    a_pu_quiet: assert property (p_pu_quiet) else $error("flag raised in power-up");
    property p_latch_win; $rose(o_reset_output_n) && o_por_flag |-> $past(o_int_pd_oe) ##1 !o_int_pd_oe; endproperty
    a_latch_win: assert property (p_latch_win) else $error("pull-down window wrong");
    property p_wd_restart;
        nrm && i_wd_failure && o_latched_pin_config |=> !o_reset_output_n && (md == `SMF_MODE_RESTART);
    endproperty
    a_wd_restart: assert property (p_wd_restart) else $error("no restart on failure");
    property p_wd_safe; nrm && i_wd_failure && !o_latched_pin_config && o_cfg_sel |=> md == `SMF_MODE_FAILSAFE; endproperty
    a_wd_safe: assert property (p_wd_safe) else $error("no fail-safe on failure");
    property p_ov_quiet;
        $rose(o_main_overvoltage_flag) && !i_overvoltage_reset_enable |=> $stable(md) && !$rose(o_fail_outputs);
    endproperty
    a_ov_quiet: assert property (p_ov_quiet) else $error("overvoltage acted while disabled");
    property p_restart_exit;
        (md == `SMF_MODE_RESTART) && ($past(md) != `SMF_MODE_RESTART) |-> ##[1:RD_MAX] (md == `SMF_MODE_NORMAL);
    endproperty
    a_restart_exit: assert property (p_restart_exit) else $error("restart not left");
    property p_init_cmd; o_reset_output_n && (md == `SMF_MODE_INIT) && i_cmd_valid |=> md == `SMF_MODE_NORMAL; endproperty
    a_init_cmd: assert property (p_init_cmd) else $error("command left init mode unchanged");
    property p_cfg_hold; $changed(o_latched_pin_config) |-> $past(o_por_flag); endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("latched config changed");
endmodule
bind smf_mode_fsm smf_mode_fsm_chk #(.RESET_DELAY_CYC(RESET_DELAY_CYC)) u_chk (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_wd_failure(i_wd_failure),
    .i_cmd_valid(i_cmd_valid), .i_overvoltage_reset_enable(i_overvoltage_reset_enable),
    .o_operating_mode_field(o_operating_mode_field), .o_latched_pin_config(o_latched_pin_config),
    .o_cfg_sel(o_cfg_sel), .o_dev_mode(o_dev_mode), .o_por_flag(o_por_flag),
    .o_main_overvoltage_flag(o_main_overvoltage_flag), .o_int_n(o_int_n),
    .o_main_undervoltage_flag(o_main_undervoltage_flag), .o_reset_output_n(o_reset_output_n),
    .o_int_pd_oe(o_int_pd_oe), .o_fail_outputs(o_fail_outputs));

// ==== smf_host_model.sv ====
/*
 * host microcontroller model: issues decoded commands one cycle each.
 * assumes callers enter cmd just after a rising clock edge.
 */
`timescale 1ns/1ps
module smf_host_model (
    // clock
    input wire i_ref_clk,
    // decoded command lines
    output logic o_cmd_valid = 1'b0,
    output logic o_mode_wr = 1'b0,
    output logic [2:0] o_mode = 3'h0,
    output logic o_wd_trigger = 1'b0,
    output logic o_fo_bit = 1'b0,
    output logic o_cfg_sel_wr = 1'b0,
    output logic o_cfg_sel = 1'b0,
    output logic o_por_clr = 1'b0,
    output logic o_ov_clr = 1'b0
);
    // op bits: 0 mode, 1 trigger, 2 test bit, 3 select wr, 4 por clr, 5 ov clr, 6 select
    // gap makes a slow host; trigger rides on any command as op bit 1
    task cmd(input logic [6:0] op, input logic [2:0] m, input int gap);
        repeat (gap) @(posedge i_ref_clk);
        if (gap > 0) #1;
        {o_cfg_sel, o_ov_clr, o_por_clr, o_cfg_sel_wr, o_fo_bit, o_wd_trigger, o_mode_wr} = op;
        o_mode = m;
        o_cmd_valid = 1'b1;
        @(posedge i_ref_clk);
        #1;
        // released strobes drop to zero and the mode shows the inverse so stale values never pass
        {o_cfg_sel, o_ov_clr, o_por_clr, o_cfg_sel_wr, o_fo_bit, o_wd_trigger, o_mode_wr} = 7'h0;
        o_mode = ~m;
        o_cmd_valid = 1'b0;
    endtask
endmodule

// ==== operating_mode_field_fsm_config_test.sv ====
/*
 * testbench for the operating-mode state machine with a host model.
 * assumes short timing parameters; the interrupt pin is modelled here.
 */
`timescale 1ns/1ps
`include "smf_defs.vh"
module operating_mode_field_fsm_config_test;
    // ------------------------------------------------------------
    // stimulus and wiring
    // ------------------------------------------------------------
    logic clk = 0, rst = 1, ok = 0, ov = 0, pu = 1, tp = 1, wk = 0, wdf = 0, ove = 0;
    logic [15:0] sc = 16'h0;
    int err_count = 0, samples_checked = 0;
    wire cv, mw, wt, fb, cw, cs, pc, oc, fo, rn, pd;
    wire [2:0] mf, md;
    // external pull-up beats the weak pull-down; floating reads high
    wire ip = pu | ~pd;
    always #2.5 clk = ~clk;
    smf_host_model host (.i_ref_clk(clk), .o_cmd_valid(cv), .o_mode_wr(mw), .o_mode(mf),
        .o_wd_trigger(wt), .o_fo_bit(fb), .o_cfg_sel_wr(cw), .o_cfg_sel(cs), .o_por_clr(pc),
        .o_ov_clr(oc));
    smf_mode_fsm #(.RESET_DELAY_CYC(20), .LONG_WINDOW_CYC(300), .CFG_FILTER_CYC(4)) dut (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_main_regulator_ok(ok), .i_main_overvoltage(ov),
        .i_int_pin(ip), .i_fail3_debug_select_pin(tp), .i_wake_event(wk), .i_cmd_valid(cv),
        .i_cmd_mode_wr(mw), .i_operating_mode_field(mf), .i_wd_trigger(wt), .i_wd_failure(wdf),
        .i_cfg_sel_wr(cw), .i_cfg_sel(cs), .i_fail_output_test_bit(fb), .i_por_flag_clr(pc),
        .i_overvoltage_reset_enable(ove), .i_ov_flag_clr(oc), .i_cyc_wr(sc[0]),
        .i_cyc_sense_hs_en(sc[4:1]), .i_cyc_sense_timer(sc[5]), .i_cyc_wake_en(sc[6]),
        .i_cyc_wake_timer(sc[7]), .i_supply_on_wr(sc[8]), .i_second_regulator_on(sc[9]),
        .i_third_regulator_on(sc[10]), .i_transceiver_on(sc[11]), .i_high_side_switches_on(sc[15:12]),
        .o_operating_mode_field(md), .o_cfg_sel(), .o_latched_pin_config(), .o_dev_mode(),
        .o_por_flag(), .o_main_overvoltage_flag(), .o_main_undervoltage_flag(), .o_wd_fail_cnt(),
        .o_wd_window_long(), .o_wd_run(), .o_reset_output_n(rn), .o_int_pd_oe(pd), .o_int_n(),
        .o_fail_outputs(fo), .o_second_regulator_en(), .o_third_regulator_en(), .o_transceiver_en(),
        .o_high_side_switches_en(), .o_cyc_sense_hs_en(), .o_cyc_sense_timer(), .o_cyc_wake_en(),
        .o_cyc_wake_timer());
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // wait for reset release; uns makes the pin flip faster than the filter
    task wrel(input logic uns);
        int i;
        i = 0;
        while (rn !== 1'b1 && i < 200) begin
            if (uns) pu = i[1];
            tk(1);
            i++;
        end
        chk("release", 1, i < 200);
        tk(2);
    endtask
    task pwr(input logic uns);
        rst = 1;
        ok = 0;
        tk(4);
        rst = 0;
        tk(2);
        ok = 1;
        tk(6);
        chk("pd_on", 1, pd);
        chk("ro_low", 0, rn);
        chk("uv", 0, dut.o_main_undervoltage_flag);
        wrel(uns);
    endtask
    task wd_fail;
        wdf = 1;
        tk(1);
        wdf = 0;
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        pwr(0);
        chk("mode", `SMF_MODE_INIT, md);
        chk("long", 1, dut.o_wd_window_long);
        chk("latched_pin_config", 1, dut.o_latched_pin_config);
        chk("sel", `SMF_CFG_SEL_RST, dut.o_cfg_sel);
        chk("dev", 0, dut.o_dev_mode);
        wk = 1;
        tk(4);
        chk("int_init", 1, dut.o_int_n);
        wk = 0;
        host.cmd(7'h02, 3'h0, 0);
        tk(1);
        chk("mode", `SMF_MODE_NORMAL, md);
        chk("second_regulator", 0, dut.o_second_regulator_en);
        chk("third_regulator", 0, dut.o_third_regulator_en);
        chk("can", 0, dut.o_transceiver_en);
        chk("fo", 0, fo);
        wk = 1;
        tk(4);
        chk("int_norm", 0, dut.o_int_n);
        chk("mode", `SMF_MODE_NORMAL, md);
        wk = 0;
        sc = 16'hfff5;
        tk(1);
        sc = 16'h0;
        tk(1);
        chk("cyc", 8'haf, {dut.o_cyc_sense_hs_en, dut.o_cyc_sense_timer, dut.o_cyc_wake_en,
            dut.o_cyc_wake_timer, 1'b1});
        chk("hs", 8'h0f, dut.o_high_side_switches_en);
        host.cmd(7'h04, 3'h0, 3);
        tk(1);
        chk("fail_output_test_bit", 1, fo);
        host.cmd(7'h00, 3'h0, 0);
        tk(1);
        chk("fo_off", 0, fo);
        host.cmd(7'h01, 3'h5, 0);
        tk(1);
        chk("bad_mode", `SMF_MODE_NORMAL, md);
        ov = 1;
        tk(6);
        chk("ov_flag", 1, dut.o_main_overvoltage_flag);
        chk("ov_mode", `SMF_MODE_NORMAL, md);
        chk("ov_fo", 0, fo);
        ov = 0;
        host.cmd(7'h20, 3'h0, 0);
        pu = 0;
        wd_fail();
        chk("ro_wd", 0, rn);
        chk("mode", `SMF_MODE_RESTART, md);
        chk("fo_wd", 1, fo);
        wrel(0);
        chk("mode", `SMF_MODE_NORMAL, md);
        chk("relatch", 0, dut.o_latched_pin_config);
        chk("hs_off", 8'h00, dut.o_high_side_switches_en);
        chk("third_regulator_kept", 1, dut.o_third_regulator_en);
        chk("fo_kept", 1, fo);
        // fresh power-up so the failure count of config 4 starts from zero
        pwr(0);
        host.cmd(7'h1a, 3'h0, 0);
        tk(1);
        chk("sel0", 0, dut.o_cfg_sel);
        pu = 1;
        wd_fail();
        chk("cfg4_first", `SMF_MODE_RESTART, md);
        wrel(0);
        chk("latched_pin_config_kept", 0, dut.o_latched_pin_config);
        wd_fail();
        chk("cfg4_second", `SMF_MODE_FAILSAFE, md);
        $display("test power-on and normal mode done");
        // no command and no trigger: the long window runs out
        pwr(0);
        repeat (400) begin
            if (md === `SMF_MODE_INIT) tk(1);
        end
        chk("no_trig", `SMF_MODE_RESTART, md);
        wrel(0);
        chk("mode", `SMF_MODE_NORMAL, md);
        ove = 1;
        ov = 1;
        tk(6);
        chk("ov_rst", `SMF_MODE_RESTART, md);
        chk("ov_flag", 1, dut.o_main_overvoltage_flag);
        chk("ov_fo", 1, fo);
        ov = 0;
        wrel(0);
        $display("test watchdog window and overvoltage done");
        tp = 0;
        pwr(1);
        chk("unstable", 0, dut.o_latched_pin_config);
        chk("dev", 1, dut.o_dev_mode);
        host.cmd(7'h02, 3'h0, 0);
        tk(1);
        wd_fail();
        chk("dev_wd", `SMF_MODE_NORMAL, md);
        ov = 1;
        tk(6);
        chk("ov_safe", `SMF_MODE_FAILSAFE, md);
        $display("test unstable pin and development mode done");
        conclude();
    end
    // the whole run needs well under two thousand cycles
    initial begin
        #50000;
        err_count++;
        conclude();
    end
endmodule
